// ===== shared/otp_fuse_defines.svh
// Constants for the fuse bank reader: geometry, field layout, register map and timing.
`ifndef OTP_FUSE_DEFINES_SVH
`define OTP_FUSE_DEFINES_SVH

// ==========================================================
// Geometry
`define FUSE_TOTAL_BITS 768
`define FUSE_BANKS 6
`define FUSE_BANK_BITS 128
`define FUSE_FIXED_BITS 108
`define FUSE_SPARE_BITS 20
`define FUSE_SKIP_BANK 3'h2

// ==========================================================
// Bank bit map (positions inside one bank)
`define FLD_BANK_USED 0
`define FLD_BANK_INVALID 1
`define FLD_HWA_VALID 2
`define FLD_HWA_LSB 3
`define FLD_HWA_W 48
`define FLD_ADC_VALID 51
`define FLD_ADC_LSB 52
`define FLD_ADC_W 16
`define FLD_FOFS_VALID 68
`define FLD_FOFS_LSB 69
`define FLD_FOFS_W 15
`define FLD_IQG_VALID 84
`define FLD_IQG_LSB 85
`define FLD_IQG_W 11
`define FLD_IQP_VALID 96
`define FLD_IQP_LSB 97
`define FLD_IQP_W 11
`define FLD_SPARE_LSB 108

// ==========================================================
// Register byte offsets
`define REG_STATUS 12'h000
`define REG_HWA_LO 12'h004
`define REG_HWA_HI 12'h008
`define REG_ADC 12'h00C
`define REG_FOFS 12'h010
`define REG_IQ 12'h014
`define REG_SPARE 12'h018
`define REG_PROG_CTRL 12'h01C
`define REG_PROG_DATA 12'h020
`define REG_RAW_SEL 12'h024
`define REG_RAW_DATA 12'h028

// ==========================================================
// Reset values and timing
`define PROG_CTRL_RST 32'h0000_0000
`define PROG_PULSE_NS 1000
`define CLK_PERIOD_NS 8
`define PROG_PULSE_CYC ((`PROG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== shared/otp_fuse_pkg.sv
// Types shared by the fuse bank reader files.
package otp_fuse_pkg;
	typedef enum logic [1:0] {
		ST_LOAD,
		ST_IDLE,
		ST_BURN,
		ST_RELOAD
	} fuse_state_t;
endpackage

// ===== hdl/fuse_bank_store.sv
// One fuse bank: 128 one-time bits that can only be set.
`timescale 1ns/1ps
`default_nettype none
module fuse_bank_store #(
	parameter int BITS = 128,
	parameter logic [BITS-1:0] SHIPPED = '0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic burn,
	input wire logic [BITS-1:0] burn_mask,
	output logic [BITS-1:0] bits
);
	logic [BITS-1:0] fuse_q;
	logic strap_q;
	logic [BITS-1:0] fuse_d;

	// Bits only ever OR in; a zero in the mask cannot clear a blown fuse
	assign fuse_d = fuse_q | (burn ? burn_mask : '0);

	// Shipped contents are loaded once after reset release, as a clocked capture
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fuse_q <= '0;
			strap_q <= 1'b0;
		end else if (ce) begin
			strap_q <= 1'b1;
			fuse_q <= strap_q ? fuse_d : (fuse_q | SHIPPED);
		end
	end

	assign bits = fuse_q;
endmodule // fuse_bank_store
`default_nettype wire

// ===== hdl/otp_bank_fuse_reader.sv
// Fuse bank reader: six one-time banks, active bank choice, field presentation over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "otp_fuse_defines.svh"
module otp_bank_fuse_reader
	import otp_fuse_pkg::*;
#(
	parameter int BANKS = `FUSE_BANKS,
	parameter int BANK_BITS = `FUSE_BANK_BITS,
	parameter logic HAS_HW_ADDR = 1'b0,
	parameter logic [47:0] SHIPPED_HW_ADDR = 48'h0000_0000_0000,
	parameter logic [10:0] SHIPPED_IQ_GAIN = 11'h000,
	parameter logic [10:0] SHIPPED_IQ_PHASE = 11'h000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic fields_ready,
	output logic no_valid_data,
	output logic [2:0] active_bank,
	output logic [47:0] hw_address_field,
	output logic hw_address_valid,
	output logic iq_gain_cal_valid,
	output logic [10:0] iq_gain_cal_field,
	output logic iq_phase_cal_valid,
	output logic [10:0] iq_phase_cal_field
);
	// ==========================================================
	// Fuse array
	localparam logic [BANK_BITS-1:0] BANK0_SHIP = BANK_BITS'(
		(128'(HAS_HW_ADDR) << `FLD_HWA_VALID) |
		(128'(HAS_HW_ADDR ? SHIPPED_HW_ADDR : 48'h0) << `FLD_HWA_LSB) |
		(128'h1 << `FLD_IQG_VALID) | (128'(SHIPPED_IQ_GAIN) << `FLD_IQG_LSB) |
		(128'h1 << `FLD_IQP_VALID) | (128'(SHIPPED_IQ_PHASE) << `FLD_IQP_LSB) |
		(128'h1 << `FLD_BANK_USED));

	logic [BANK_BITS-1:0] bank_bits [BANKS];
	logic [BANKS-1:0] bank_burn;
	logic [BANK_BITS-1:0] prog_data_q;
	logic [2:0] prog_bank_q;
	logic [$clog2(`PROG_PULSE_CYC+1)-1:0] burn_cnt_q;
	fuse_state_t state_q;

	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : g_bank
			// Banks burn one at a time, independently of the others
			assign bank_burn[g] = (state_q == ST_BURN) && (prog_bank_q == 3'(g));
			fuse_bank_store #(
				.BITS(BANK_BITS),
				.SHIPPED(g == 0 ? BANK0_SHIP : '0)
			) u_bank (
				.clk(clk),
				.rst_b(rst_b),
				.ce(ce),
				.burn(bank_burn[g]),
				.burn_mask(prog_data_q),
				.bits(bank_bits[g])
			);
		end
	endgenerate

	// ==========================================================
	// Active bank selection
	logic [2:0] pick;
	logic pick_ok;
	always_comb begin
		pick = 3'h0;
		pick_ok = 1'b0;
		for (int i = 0; i < BANKS; i++) begin
			if (bank_bits[i][`FLD_BANK_USED] && !bank_bits[i][`FLD_BANK_INVALID]) begin
				pick = 3'(i);
				pick_ok = 1'b1;
			end
		end
	end
	wire [BANK_BITS-1:0] act = bank_bits[pick];

	// ==========================================================
	// Sequencer: load fields after reset, burn on request, reload after burn
	logic burn_go;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_LOAD;
			burn_cnt_q <= '0;
		end else if (ce) begin
			case (state_q)
				ST_LOAD: state_q <= ST_RELOAD;
				ST_IDLE: if (burn_go) begin
					state_q <= ST_BURN;
					burn_cnt_q <= '0;
				end
				ST_BURN: begin
					burn_cnt_q <= burn_cnt_q + 1'b1;
					if (burn_cnt_q == ($bits(burn_cnt_q))'(`PROG_PULSE_CYC - 1))
						state_q <= ST_RELOAD;
				end
				ST_RELOAD: state_q <= ST_IDLE;
				default: state_q <= ST_LOAD;
			endcase
		end
	end

	// Field registers follow the active bank; invalid fields read as zero
	wire hwa_ok = pick_ok && act[`FLD_HWA_VALID];
	wire iqg_ok = pick_ok && act[`FLD_IQG_VALID];
	wire iqp_ok = pick_ok && act[`FLD_IQP_VALID];
	logic [15:0] adc_q;
	logic [14:0] fofs_q;
	logic [19:0] spare_q;
	logic adc_ok_q;
	logic fofs_ok_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fields_ready <= 1'b0;
			no_valid_data <= 1'b0;
			active_bank <= 3'h0;
			hw_address_field <= 48'h0;
			hw_address_valid <= 1'b0;
			iq_gain_cal_valid <= 1'b0;
			iq_gain_cal_field <= 11'h0;
			iq_phase_cal_valid <= 1'b0;
			iq_phase_cal_field <= 11'h0;
			adc_q <= 16'h0;
			fofs_q <= 15'h0;
			spare_q <= 20'h0;
			adc_ok_q <= 1'b0;
			fofs_ok_q <= 1'b0;
		end else if (ce && state_q == ST_RELOAD) begin
			fields_ready <= 1'b1;
			no_valid_data <= !pick_ok;
			active_bank <= pick;
			hw_address_valid <= hwa_ok;
			hw_address_field <= hwa_ok ? act[`FLD_HWA_LSB +: `FLD_HWA_W] : 48'h0;
			iq_gain_cal_valid <= iqg_ok;
			iq_gain_cal_field <= iqg_ok ? act[`FLD_IQG_LSB +: `FLD_IQG_W] : 11'h0;
			iq_phase_cal_valid <= iqp_ok;
			iq_phase_cal_field <= iqp_ok ? act[`FLD_IQP_LSB +: `FLD_IQP_W] : 11'h0;
			adc_ok_q <= pick_ok && act[`FLD_ADC_VALID];
			adc_q <= (pick_ok && act[`FLD_ADC_VALID]) ? act[`FLD_ADC_LSB +: `FLD_ADC_W] : 16'h0;
			fofs_ok_q <= pick_ok && act[`FLD_FOFS_VALID];
			fofs_q <= (pick_ok && act[`FLD_FOFS_VALID]) ? act[`FLD_FOFS_LSB +: `FLD_FOFS_W] : 15'h0;
			spare_q <= pick_ok ? act[`FLD_SPARE_LSB +: `FUSE_SPARE_BITS] : 20'h0;
		end
	end

	// ==========================================================
	// AHB-Lite slave: zero wait state, always OKAY
	logic wr_pend_q;
	logic [11:0] addr_q;
	logic [4:0] raw_sel_q;
	wire take = hsel && hready && htrans[1];
	wire [31:0] raw_word = bank_bits[raw_sel_q[4:2]][raw_sel_q[1:0]*32 +: 32];
	wire wr_data = wr_pend_q && addr_q == `REG_PROG_DATA;
	wire [1:0] data_word = prog_bank_q[1:0];
	assign burn_go = wr_pend_q && addr_q == `REG_PROG_CTRL && hwdata[31] && hwdata[2:0] < 3'(BANKS);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_q <= 1'b0;
			addr_q <= 12'h0;
			raw_sel_q <= 5'h0;
			prog_bank_q <= 3'h0;
			prog_data_q <= '0;
		end else if (ce) begin
			wr_pend_q <= take && hwrite;
			if (take)
				addr_q <= haddr;
			if (wr_pend_q && addr_q == `REG_RAW_SEL && hwdata[4:2] < 3'(BANKS))
				raw_sel_q <= hwdata[4:0];
			if (wr_pend_q && addr_q == `REG_PROG_CTRL && state_q == ST_IDLE)
				prog_bank_q <= hwdata[2:0];
			// Data words shift in low word first; four writes fill a bank image
			if (wr_data)
				prog_data_q <= {hwdata, prog_data_q[BANK_BITS-1:32]};
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		case (haddr)
			`REG_STATUS: rd_mux = {24'h0, state_q == ST_BURN, active_bank, 2'b00, no_valid_data, fields_ready};
			`REG_HWA_LO: rd_mux = hw_address_field[31:0];
			`REG_HWA_HI: rd_mux = {15'h0, hw_address_valid, hw_address_field[47:32]};
			`REG_ADC: rd_mux = {15'h0, adc_ok_q, adc_q};
			`REG_FOFS: rd_mux = {16'h0, fofs_ok_q, fofs_q};
			`REG_IQ: rd_mux = {4'h0, iq_phase_cal_valid, iq_phase_cal_field, 4'h0, iq_gain_cal_valid,
				iq_gain_cal_field};
			`REG_SPARE: rd_mux = {12'h0, spare_q};
			`REG_PROG_CTRL: rd_mux = {29'h0, prog_bank_q};
			`REG_RAW_SEL: rd_mux = {27'h0, raw_sel_q};
			`REG_RAW_DATA: rd_mux = raw_word;
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			hrdata <= 32'h0;
		else if (ce && take && !hwrite)
			hrdata <= rd_mux;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	logic unused_ok;
	assign unused_ok = ^{hsize, data_word};
endmodule // otp_bank_fuse_reader
`default_nettype wire

// ===== verif/otp_fuse_reader_properties.sv
// Checker for the fuse bank reader outputs, bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module otp_fuse_reader_properties (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic fields_ready,
	input wire logic no_valid_data,
	input wire logic [2:0] active_bank,
	input wire logic [47:0] hw_address_field,
	input wire logic hw_address_valid,
	input wire logic iq_gain_cal_valid,
	input wire logic [10:0] iq_gain_cal_field,
	input wire logic iq_phase_cal_valid,
	input wire logic [10:0] iq_phase_cal_field
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_bus_ready: assert property (hreadyout && !hresp)
		else $error("bus not ready or error response");
	chk_ready_sticky: assert property (fields_ready |=> fields_ready)
		else $error("fields ready dropped");
	chk_bank_range: assert property (active_bank <= 3'h5)
		else $error("active bank out of range");
	chk_hwa_masked: assert property (!hw_address_valid |-> hw_address_field == 48'h0)
		else $error("address shown while invalid");
	chk_gain_masked: assert property (!iq_gain_cal_valid |-> iq_gain_cal_field == 11'h0)
		else $error("gain shown while invalid");
	chk_phase_masked: assert property (!iq_phase_cal_valid |-> iq_phase_cal_field == 11'h0)
		else $error("phase shown while invalid");
	chk_nodata_flags: assert property (no_valid_data |-> !(hw_address_valid || iq_gain_cal_valid || iq_phase_cal_valid))
		else $error("valid field without a usable bank");
	// A move of the active bank needs a full burn before the next reload, so it cannot move again soon after
	chk_bank_hold: assert property ($changed(active_bank) |=> $stable(active_bank) [*8])
		else $error("active bank moved without reload");
	cov_nodata: cover property (no_valid_data);
	cov_bank3: cover property (active_bank == 3'h3 && hw_address_valid);
	cov_bank5: cover property (active_bank == 3'h5);
endmodule // otp_fuse_reader_properties
bind otp_bank_fuse_reader otp_fuse_reader_properties u_props (.clk(clk), .rst_b(rst_b), .hreadyout(hreadyout),
	.hresp(hresp), .fields_ready(fields_ready), .no_valid_data(no_valid_data), .active_bank(active_bank),
	.hw_address_field(hw_address_field), .hw_address_valid(hw_address_valid), .iq_gain_cal_valid(iq_gain_cal_valid),
	.iq_gain_cal_field(iq_gain_cal_field), .iq_phase_cal_valid(iq_phase_cal_valid),
	.iq_phase_cal_field(iq_phase_cal_field));
`default_nettype wire

// ===== verif/fuse_prog_agent.sv
// Bus master model of the processor and fuse programming agent.
`timescale 1ns/1ps
`default_nettype none
`include "otp_fuse_defines.svh"
module fuse_prog_agent (
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [11:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// ==========================================================
	// Bus cycles
	initial begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge clk);
		while (!hready) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= w ? wd : ~hwdata;
		@(posedge clk);
		while (!hready) @(posedge clk);
		rd = hrdata;
	endtask
	// Words first, then the burn; the caller orders invalidate, fields, used flag
	task automatic prog(input logic [2:0] b, input logic [127:0] v);
		int i;
		logic [31:0] s;
		for (i = 0; i < 4; i++) xfer(1'b1, `REG_PROG_DATA, v[32*i +: 32], s);
		xfer(1'b1, `REG_PROG_CTRL, {1'b1, 28'h0, b}, s);
		repeat (2) @(posedge clk);
		s = 32'hFFFF_FFFF;
		for (i = 0; i < 400 && s[7]; i++) xfer(1'b0, `REG_STATUS, 32'h0, s);
		repeat (3) @(posedge clk);
	endtask
endmodule // fuse_prog_agent
`default_nettype wire

// ===== verif/otp_bank_fuse_reader_bench.sv
// Self-checking bench: fuse bank model compared with the reader at every step.
`timescale 1ns/1ps
`default_nettype none
`include "otp_fuse_defines.svh"
module otp_bank_fuse_reader_bench;
	import otp_fuse_pkg::*;
	// ==========================================================
	// Clock, reset, wiring
	logic clk = 1'b0, rst_b = 1'b0, hsel, hwrite, hrdy, hresp, frdy, nvd, hwv, gv, pv;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, abank;
	logic [31:0] hwdata, hrdata, d;
	logic [47:0] hwa;
	logic [10:0] gf, pf;
	logic [127:0] mdl [6];
	logic [127:0] w;
	int err_total = 0, checks_done = 0;
	always #4 clk = ~clk;
	otp_bank_fuse_reader #(.SHIPPED_IQ_GAIN(11'h2A5), .SHIPPED_IQ_PHASE(11'h13C)) dut (.clk(clk), .rst_b(rst_b),
		.ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .fields_ready(frdy), .no_valid_data(nvd),
		.active_bank(abank), .hw_address_field(hwa), .hw_address_valid(hwv), .iq_gain_cal_valid(gv),
		.iq_gain_cal_field(gf), .iq_phase_cal_valid(pv), .iq_phase_cal_field(pf));
	fuse_prog_agent agent (.clk(clk), .hready(hrdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// ==========================================================
	// Checking helpers
	task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk_all;
		int b, a;
		logic [127:0] v;
		logic [31:0] s, r;
		a = -1;
		for (b = 0; b < 6; b++) if (mdl[b][0] && !mdl[b][1]) a = b;
		v = (a < 0) ? 128'h0 : mdl[a];
		agent.xfer(1'b0, `REG_STATUS, 32'h0, s);
		cmp("status", {1'b0, a < 0, 1'b1}, {s[7], s[1:0]});
		if (a >= 0) cmp("status bank", a, s[6:4]);
		agent.xfer(1'b0, `REG_HWA_LO, 32'h0, s);
		agent.xfer(1'b0, `REG_HWA_HI, 32'h0, r);
		cmp("hwa regs", {v[2], v[2] ? v[50:3] : 48'h0}, {r[16], r[15:0], s});
		agent.xfer(1'b0, `REG_ADC, 32'h0, s);
		cmp("adc", {v[51], v[51] ? v[67:52] : 16'h0}, s[16:0]);
		agent.xfer(1'b0, `REG_FOFS, 32'h0, s);
		cmp("fofs", {v[68], v[68] ? v[83:69] : 15'h0}, s[15:0]);
		agent.xfer(1'b0, `REG_SPARE, 32'h0, s);
		cmp("spare", v[127:108], s);
		cmp("no data", a < 0, nvd);
		if (a >= 0) cmp("bank", a, abank);
		cmp("hwa", {v[2], v[2] ? v[50:3] : 48'h0}, {hwv, hwa});
		cmp("gain", {v[84], v[84] ? v[95:85] : 11'h0}, {gv, gf});
		cmp("phase", {v[96], v[96] ? v[107:97] : 11'h0}, {pv, pf});
	endtask
	task automatic p(input logic [2:0] b, input logic [127:0] v);
		agent.prog(b, v);
		mdl[b] = mdl[b] | v;
		chk_all;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		#200000;
		err_total++;
		stop_test;
	end
	initial begin
		d = $urandom(32'hE29BDC02);
		foreach (mdl[i]) mdl[i] = 128'h0;
		mdl[0][0] = 1'b1;
		mdl[0][84] = 1'b1;
		mdl[0][95:85] = 11'h2A5;
		mdl[0][96] = 1'b1;
		mdl[0][107:97] = 11'h13C;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		cmp("ready", 1'b1, frdy);
		chk_all;
		agent.xfer(1'b0, `REG_IQ, 32'h0, d);
		cmp("iq reg", {4'h0, 1'b1, 11'h13C, 4'h0, 1'b1, 11'h2A5}, d);
		agent.xfer(1'b0, 12'h0FC, 32'h0, d);
		cmp("unmapped", 32'h0, d);
		$display("test 1 done");
		w = 128'h0;
		w[50:3] = 48'({$urandom, $urandom});
		w[2] = 1'b1;
		w[51] = 1'b1;
		w[67:52] = 16'($urandom);
		w[68] = 1'b1;
		w[83:69] = 15'($urandom);
		w[84] = 1'b1;
		w[95:85] = 11'($urandom);
		w[96] = 1'b1;
		w[107:97] = 11'($urandom);
		w[127:108] = 20'($urandom);
		p(3'h0, 128'h2);
		p(3'h2, 128'h2);
		p(3'h3, w);
		p(3'h3, 128'h1);
		$display("test 2 done");
		p(3'h3, 128'h0);
		agent.xfer(1'b1, `REG_PROG_CTRL, {1'b1, 28'h0, 3'h6}, d);
		agent.xfer(1'b0, `REG_STATUS, 32'h0, d);
		cmp("refused burn", 1'b0, d[7]);
		repeat (140) @(posedge clk);
		for (int i = 0; i < 24; i++) begin
			agent.xfer(1'b1, `REG_RAW_SEL, 32'(i), d);
			agent.xfer(1'b0, `REG_RAW_DATA, 32'h0, d);
			cmp("raw", mdl[i / 4][32 * (i % 4) +: 32], d);
		end
		$display("test 3 done");
		p(3'h5, {20'h0, 12'h0, 11'($urandom), 85'h1 | (85'h1 << 84)});
		$display("test 4 done");
		stop_test;
	end
endmodule // otp_bank_fuse_reader_bench
`default_nettype wire
